// ==== rtl/mad_decoder.v ====
// address decoder for the register file and program spaces
// assumes: single clk, synchronous active-low rstn; the core issues at most
// one register and one program access per cycle; targets answer in the strobe cycle
`include "mad_consts.vh"
module mad_decoder #(
  parameter RAM_SIZE   = `MAD_RAM_MAX,
  parameter FLASH_SIZE = `MAD_FLASH_DEF
) (
  input  wire                    clk,
  input  wire                    rstn,
  // register file request from the core
  input  wire                    regReq,
  input  wire                    regWe,
  input  wire [`MAD_RADDR_W-1:0] regAddr,
  input  wire [7:0]              regWdata,
  output reg  [7:0]              regRdata,
  output reg                     regRvalid,
  // RAM port
  output reg                     ramReq,
  output reg                     ramWe,
  output reg  [`MAD_RADDR_W-1:0] ramAddr,
  output reg  [7:0]              ramWdata,
  input  wire [7:0]              ramRdata,
  // control register port
  output reg                     ctrlReq,
  output reg                     ctrlWe,
  output reg  [7:0]              ctrlAddr,
  output reg  [7:0]              ctrlWdata,
  input  wire [7:0]              ctrlRdata,
  // program memory request from the core
  input  wire                    progReq,
  input  wire                    progWe,
  input  wire [`MAD_PADDR_W-1:0] progAddr,
  input  wire [7:0]              progWdata,
  output reg  [7:0]              progRdata,
  output reg                     progRvalid,
  output reg  [`MAD_REG_W-1:0]   progRegion,
  // flash port
  output reg                     flashReq,
  output reg                     flashWe,
  output reg  [`MAD_PADDR_W-1:0] flashAddr,
  output reg  [7:0]              flashWdata,
  input  wire [7:0]              flashRdata
);
  // RAM limit widened so a full 4KB part compares cleanly
  localparam [`MAD_RADDR_W:0] RAM_LIM = RAM_SIZE[`MAD_RADDR_W:0];

  // ==========================================================================
  // register space selection
  function [`MAD_RSEL_W-1:0] regSel;
    input [`MAD_RADDR_W-1:0] a;
    begin
      if (a >= `MAD_CTRL_BASE)
        regSel = `MAD_RSEL_CTRL;
      else if ({1'b0, a} < RAM_LIM)
        regSel = `MAD_RSEL_RAM;
      else
        regSel = `MAD_RSEL_HOLE;
    end
  endfunction

  // ==========================================================================
  // program address below the flash top
  function inFlash;
    input [`MAD_REG_W-1:0] r;
    begin
      inFlash = (r != `MAD_REG_NONE);
    end
  endfunction

  wire [`MAD_RSEL_W-1:0] regSelNow = regSel(regAddr);
  wire [`MAD_REG_W-1:0]  progRegNow;
  reg  [`MAD_RSEL_W-1:0] rdSel_q;
  reg                    rdPend_q;
  reg                    progPend_q;
  reg                    progHit_q;
  // next values of both request stages
  reg                    ramReq_d;
  reg                    ramWe_d;
  reg                    ctrlReq_d;
  reg                    ctrlWe_d;
  reg  [`MAD_RSEL_W-1:0] rdSel_d;
  reg                    rdPend_d;
  reg  [7:0]             regRdata_d;
  reg                    flashReq_d;
  reg                    flashWe_d;
  reg                    progPend_d;
  reg                    progHit_d;
  reg  [`MAD_REG_W-1:0]  progRegion_d;
  reg  [7:0]             progRdata_d;

  // ==========================================================================
  // program region lookup
  mad_prog_region #(
    .FLASH_SIZE (FLASH_SIZE)
  ) uRegion (
    .progAddr (progAddr),
    .region   (progRegNow)
  );

  // ==========================================================================
  // register side next values, one target strobe at most
  always @* begin
    ramReq_d  = 1'b0;
    ramWe_d   = 1'b0;
    ctrlReq_d = 1'b0;
    ctrlWe_d  = 1'b0;
    rdSel_d   = regSelNow;
    rdPend_d  = regReq && !regWe;
    if (regReq) begin
      case (regSelNow)
        `MAD_RSEL_RAM: begin
          ramReq_d = 1'b1;
          ramWe_d  = regWe;
        end
        `MAD_RSEL_CTRL: begin
          // control range forwarded whole, reserved slots included
          ctrlReq_d = 1'b1;
          ctrlWe_d  = regWe;
        end
        default: begin
          // hole access reaches neither target, writes are lost
          ramReq_d  = 1'b0;
          ctrlReq_d = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // register side read data, held between read returns
  always @* begin
    regRdata_d = regRdata;
    if (rdPend_q) begin
      case (rdSel_q)
        `MAD_RSEL_RAM:  regRdata_d = ramRdata;
        `MAD_RSEL_CTRL: regRdata_d = ctrlRdata;
        default:        regRdata_d = `MAD_ZERO_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // register side request stage
  always @(posedge clk) begin
    if (!rstn) begin
      ramReq    <= 1'b0;
      ramWe     <= 1'b0;
      ramAddr   <= {`MAD_RADDR_W{1'b0}};
      ramWdata  <= `MAD_ZERO_BYTE;
      ctrlReq   <= 1'b0;
      ctrlWe    <= 1'b0;
      ctrlAddr  <= `MAD_ZERO_BYTE;
      ctrlWdata <= `MAD_ZERO_BYTE;
      rdSel_q   <= `MAD_RSEL_RAM;
      rdPend_q  <= 1'b0;
    end else begin
      ramReq    <= ramReq_d;
      ramWe     <= ramWe_d;
      ramAddr   <= regAddr;
      ramWdata  <= regWdata;
      ctrlReq   <= ctrlReq_d;
      ctrlWe    <= ctrlWe_d;
      ctrlAddr  <= regAddr[`MAD_CTRL_AW-1:0];
      ctrlWdata <= regWdata;
      rdSel_q   <= rdSel_d;
      rdPend_q  <= rdPend_d;
    end
  end

  // ==========================================================================
  // register side read return, one cycle after the target request
  always @(posedge clk) begin
    if (!rstn) begin
      regRdata  <= `MAD_ZERO_BYTE;
      regRvalid <= 1'b0;
    end else begin
      regRdata  <= regRdata_d;
      regRvalid <= rdPend_q;
    end
  end

  // ==========================================================================
  // program side next values, nothing reaches flash above its top
  always @* begin
    flashReq_d   = progReq && inFlash(progRegNow);
    flashWe_d    = progReq && progWe && inFlash(progRegNow);
    progPend_d   = progReq && !progWe;
    progHit_d    = inFlash(progRegNow);
    progRegion_d = progRegion;
    if (progReq)
      progRegion_d = progRegNow;
  end

  // ==========================================================================
  // program side read data, erased byte outside the flash
  always @* begin
    progRdata_d = progRdata;
    if (progPend_q) begin
      if (progHit_q)
        progRdata_d = flashRdata;
      else
        progRdata_d = `MAD_ERASED_BYTE;
    end
  end

  // ==========================================================================
  // program side request stage
  always @(posedge clk) begin
    if (!rstn) begin
      flashReq   <= 1'b0;
      flashWe    <= 1'b0;
      flashAddr  <= {`MAD_PADDR_W{1'b0}};
      flashWdata <= `MAD_ZERO_BYTE;
      progPend_q <= 1'b0;
      progHit_q  <= 1'b0;
      progRegion <= `MAD_REG_OPT;
    end else begin
      flashReq   <= flashReq_d;
      flashWe    <= flashWe_d;
      flashAddr  <= progAddr;
      flashWdata <= progWdata;
      progPend_q <= progPend_d;
      progHit_q  <= progHit_d;
      progRegion <= progRegion_d;
    end
  end

  // ==========================================================================
  // program side read return
  always @(posedge clk) begin
    if (!rstn) begin
      progRdata  <= `MAD_ZERO_BYTE;
      progRvalid <= 1'b0;
    end else begin
      progRdata  <= progRdata_d;
      progRvalid <= progPend_q;
    end
  end
endmodule

// ==== rtl/mad_consts.vh ====
// constants for the memory address decoder
// assumes: included by bare name from every design file of the decoder
`ifndef MAD_CONSTS_VH
`define MAD_CONSTS_VH
// ===========================================================================
// register file space
`define MAD_RADDR_W       12
`define MAD_RF_SIZE       4096
`define MAD_CTRL_BASE     12'hf00
`define MAD_CTRL_TOP      12'hfff
`define MAD_CTRL_AW       8
`define MAD_RAM_MIN       2048
`define MAD_RAM_MAX       4096
// ===========================================================================
// program space
`define MAD_PADDR_W       16
`define MAD_PROG_SIZE     65536
`define MAD_FLASH_DEF     65536
`define MAD_ERASED_BYTE   8'hff
`define MAD_ZERO_BYTE     8'h00
// ===========================================================================
// program region tops (inclusive)
`define MAD_OPT_TOP       16'h0001
`define MAD_RSTV_TOP      16'h0003
`define MAD_WDTV_TOP      16'h0005
`define MAD_TRAP_TOP      16'h0007
`define MAD_IRQV_TOP      16'h0037
// ===========================================================================
// program region codes
`define MAD_REG_W         3
`define MAD_REG_OPT       3'h0
`define MAD_REG_RSTV      3'h1
`define MAD_REG_WDTV      3'h2
`define MAD_REG_TRAP      3'h3
`define MAD_REG_IRQV      3'h4
`define MAD_REG_CODE      3'h5
`define MAD_REG_NONE      3'h6
// ===========================================================================
// register region codes
`define MAD_RSEL_W        2
`define MAD_RSEL_RAM      2'h0
`define MAD_RSEL_HOLE     2'h1
`define MAD_RSEL_CTRL     2'h2
`endif

// ==== rtl/mad_prog_region.v ====
// classifies a program address into its fixed low-memory region
// assumes: combinational, fed by the decoder on the same clock
`include "mad_consts.vh"
module mad_prog_region #(
  parameter FLASH_SIZE = `MAD_FLASH_DEF
) (
  input  wire [`MAD_PADDR_W-1:0] progAddr,
  output reg  [`MAD_REG_W-1:0]   region
);
  // flash top as a 17-bit limit so a full 64KB part fits
  localparam [`MAD_PADDR_W:0] FLASH_LIM = FLASH_SIZE[`MAD_PADDR_W:0];

  // ==========================================================================
  // flash top checked first, then regions from lowest address up
  always @* begin
    if ({1'b0, progAddr} >= FLASH_LIM)
      region = `MAD_REG_NONE;
    else if (progAddr <= `MAD_OPT_TOP)
      region = `MAD_REG_OPT;
    else if (progAddr <= `MAD_RSTV_TOP)
      region = `MAD_REG_RSTV;
    else if (progAddr <= `MAD_WDTV_TOP)
      region = `MAD_REG_WDTV;
    else if (progAddr <= `MAD_TRAP_TOP)
      region = `MAD_REG_TRAP;
    else if (progAddr <= `MAD_IRQV_TOP)
      region = `MAD_REG_IRQV;
    else
      region = `MAD_REG_CODE;
  end
endmodule

// ==== dv/mad_decoder_sva.sv ====
// checker for the address decoder ports
// assumes: bound onto mad_decoder, one clk domain, rstn sync active low
`include "mad_consts.vh"
module mad_decoder_sva #(
  parameter RAM_SIZE   = 2048,
  parameter FLASH_SIZE = 16384
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        regReq,
  input wire logic        regWe,
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regRvalid,
  input wire logic        ramReq,
  input wire logic        ramWe,
  input wire logic [11:0] ramAddr,
  input wire logic [7:0]  ramWdata,
  input wire logic        ctrlReq,
  input wire logic        ctrlWe,
  input wire logic [7:0]  ctrlAddr,
  input wire logic [7:0]  ctrlWdata,
  input wire logic        progReq,
  input wire logic        progWe,
  input wire logic [15:0] progAddr,
  input wire logic [7:0]  progWdata,
  input wire logic [7:0]  progRdata,
  input wire logic        progRvalid,
  input wire logic [2:0]  progRegion,
  input wire logic        flashReq,
  input wire logic        flashWe,
  input wire logic [15:0] flashAddr,
  input wire logic [7:0]  flashWdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire hole = regAddr >= RAM_SIZE && regAddr < `MAD_CTRL_BASE;
  // expected low-memory region of a program address
  function automatic logic [2:0] expReg(logic [15:0] a);
    if (a >= FLASH_SIZE) return `MAD_REG_NONE;
    if (a <= `MAD_OPT_TOP) return `MAD_REG_OPT;
    if (a <= `MAD_RSTV_TOP) return `MAD_REG_RSTV;
    if (a <= `MAD_WDTV_TOP) return `MAD_REG_WDTV;
    if (a <= `MAD_TRAP_TOP) return `MAD_REG_TRAP;
    return (a <= `MAD_IRQV_TOP) ? `MAD_REG_IRQV : `MAD_REG_CODE;
  endfunction
  // ==========================================================================
  // register space
  AST_RAM: assert property (regReq && regAddr < RAM_SIZE && regAddr < `MAD_CTRL_BASE |=>
    ramReq && !ctrlReq && ramAddr == $past(regAddr)) else $error("ram strobe wrong");
  AST_CTRL: assert property (regReq && regAddr >= `MAD_CTRL_BASE |=>
    ctrlReq && !ramReq && {4'h0, ctrlAddr} == ($past(regAddr) & 12'h0ff))
    else $error("ctrl strobe wrong");
  AST_HOLE: assert property (regReq && hole |=> !ramReq && !ctrlReq)
    else $error("hole access reached a target");
  AST_RVAL: assert property (regReq && !regWe |-> ##2 regRvalid)
    else $error("register read not answered");
  AST_QUIET: assert property (!regReq |=> !ramReq && !ctrlReq)
    else $error("strobe without request");
  AST_WSTRB: assert property (1'b1 |=>
    ramWe == ($past(regReq) && $past(regWe) && ramReq) &&
    ctrlWe == ($past(regReq) && $past(regWe) && ctrlReq)) else $error("write strobe wrong");
  AST_WDATA: assert property (regReq && regWe |=>
    ramWdata == $past(regWdata) && ctrlWdata == $past(regWdata))
    else $error("write data not forwarded");
  AST_NOVAL: assert property (!regReq || regWe |-> ##2 !regRvalid)
    else $error("answer without register read");
  // ==========================================================================
  // program space
  AST_FLASH: assert property (progReq && progAddr < FLASH_SIZE |=>
    flashReq && flashAddr == $past(progAddr)) else $error("flash strobe wrong");
  AST_ERASED: assert property (progReq && !progWe && progAddr >= FLASH_SIZE |=>
    !flashReq ##1 progRvalid && progRdata == `MAD_ERASED_BYTE) else $error("no ff byte");
  AST_REGION: assert property (progReq |=> progRegion == expReg($past(progAddr)))
    else $error("wrong program region");
  AST_FLWE: assert property (1'b1 |=>
    flashWe == ($past(progReq) && $past(progWe) && flashReq) &&
    flashWdata == $past(progWdata)) else $error("flash write wrong");
  cover property (regReq && hole);
  cover property (regReq && regWe && regAddr >= `MAD_CTRL_BASE);
  cover property (progReq && progAddr >= FLASH_SIZE);
  cover property (progReq && progAddr <= `MAD_TRAP_TOP);
endmodule

// ==== dv/mad_target_model.sv ====
// RAM, control and flash targets behind the decoder
// assumes: data read in the strobe cycle; idle lines toggle
module mad_target_model (
  input  wire logic        clk,
  input  wire logic        ramReq,
  input  wire logic [11:0] ramAddr,
  input  wire logic        ctrlReq,
  input  wire logic [7:0]  ctrlAddr,
  input  wire logic        flashReq,
  input  wire logic [15:0] flashAddr,
  output logic      [7:0]  ramRdata,
  output logic      [7:0]  ctrlRdata,
  output logic      [7:0]  flashRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ramQ = 8'h00, ctrlQ = 8'h00, flashQ = 8'h00;
  // address patterns while selected, inverse of last byte otherwise
  assign ramRdata = ramReq ? (ramAddr[7:0] ^ 8'h3c) : ~ramQ;
  assign ctrlRdata = ctrlReq ? ~ctrlAddr : ~ctrlQ;
  assign flashRdata = flashReq ? (flashAddr[7:0] ^ flashAddr[15:8]) : ~flashQ;
  // remember last byte on each line
  always @(posedge clk) begin
    ramQ <= ramRdata;
    ctrlQ <= ctrlRdata;
    flashQ <= flashRdata;
  end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the address decoder
// assumes: mad_decoder under rtl/, checker bound below
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam RAM_SIZE = 2048, FLASH_SIZE = 16384;
  logic clk = 0, rstn = 0, regReq = 0, regWe = 0, progReq = 0, progWe = 0;
  logic [11:0] regAddr = 0;
  logic [15:0] progAddr = 0;
  logic [7:0] regWdata = 0, progWdata = 0;
  wire [7:0] regRdata, ramWdata, ramRdata, ctrlAddr, ctrlWdata, ctrlRdata;
  wire [7:0] progRdata, flashWdata, flashRdata;
  wire [11:0] ramAddr;
  wire [15:0] flashAddr;
  wire [2:0] progRegion;
  wire regRvalid, ramReq, ramWe, ctrlReq, ctrlWe, progRvalid, flashReq, flashWe;
  int nErrors = 0, totalChecks = 0;
  logic [31:0] rs = 32'hd23d, r;
  logic [8:0] regQ[$], progQ[$];
  mad_decoder #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) u_dut (.clk, .rstn, .regReq,
    .regWe, .regAddr, .regWdata, .regRdata, .regRvalid, .ramReq, .ramWe, .ramAddr, .ramWdata,
    .ramRdata, .ctrlReq, .ctrlWe, .ctrlAddr, .ctrlWdata, .ctrlRdata, .progReq, .progWe,
    .progAddr, .progWdata, .progRdata, .progRvalid, .progRegion, .flashReq, .flashWe,
    .flashAddr, .flashWdata, .flashRdata);
  mad_target_model u_mdl (.clk, .ramReq, .ramAddr, .ctrlReq, .ctrlAddr, .flashReq,
    .flashAddr, .ramRdata, .ctrlRdata, .flashRdata);
  function automatic logic [31:0] nx();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction
  // compare one register read byte, bit 8 of the note marks a byte we care about
  task automatic cmpReg(input logic [7:0] g, input logic [8:0] e);
    if (e[8]) begin
      totalChecks++;
      if (g !== e[7:0]) begin
        nErrors++;
        $display("[ERR] %0t reg got %h exp %h", $time, g, e[7:0]);
      end
    end
  endtask
  // compare one program read byte against its note
  task automatic cmpProg(input logic [7:0] g, input logic [8:0] e);
    if (e[8]) begin
      totalChecks++;
      if (g !== e[7:0]) begin
        nErrors++;
        $display("[ERR] %0t prog got %h exp %h", $time, g, e[7:0]);
      end
    end
  endtask
  // a returned byte with no note behind it
  task automatic lost(input logic [7:0] g);
    nErrors++;
    $display("[ERR] %0t unasked byte got %h exp %h", $time, g, 8'h00);
  endtask
  task automatic results();
    if (nErrors == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  // ==========================================================================
  // watch returns, match against oldest note
  always @(negedge clk) if (rstn) begin
    if (regRvalid === 1'b1) begin
      if (regQ.size() == 0) lost(regRdata);
      else cmpReg(regRdata, regQ.pop_front());
    end
    if (progRvalid === 1'b1) begin
      if (progQ.size() == 0) lost(progRdata);
      else cmpProg(progRdata, progQ.pop_front());
    end
  end
  // ==========================================================================
  // random back-to-back traffic across every boundary
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    repeat (800) begin
      r = nx();
      regReq = r[0] | r[1];
      case (r[5:4])
        2'd0: regAddr = {1'b0, r[16:6]};
        2'd1: regAddr = 12'h7fe + r[7:6];
        2'd2: regAddr = 12'hefe + r[7:6];
        default: regAddr = r[31:20];
      endcase
      // control writes only to the low timer slots, reserved slots left alone
      regWe = r[2] & r[3] & (regAddr < 12'hf20);
      regWdata = r[15:8];
      // RAM pattern below RAM top, inverted low address from control slots
      if (regReq && !regWe) regQ.push_back({regAddr < RAM_SIZE ||
        (regAddr >= 12'hf00 && regAddr < 12'hf20),
        (regAddr >= 12'hf00) ? ~regAddr[7:0] : regAddr[7:0] ^ 8'h3c});
      r = nx();
      progReq = r[0];
      progWe = r[1] & r[2];
      progWdata = r[15:8];
      case (r[4:3])
        2'd0: progAddr = {10'h0, r[10:5]};
        2'd1: progAddr = 16'(FLASH_SIZE - 2 + r[6:5]);
        default: progAddr = r[31:16];
      endcase
      if (progReq && !progWe) progQ.push_back({1'b1, (progAddr < FLASH_SIZE) ?
        progAddr[7:0] ^ progAddr[15:8] : 8'hff});
      @(negedge clk);
    end
    regReq = 0;
    progReq = 0;
    repeat (10) @(negedge clk);
    if (regQ.size() != 0 || progQ.size() != 0) nErrors++;
    results();
  end
endmodule
bind mad_decoder mad_decoder_sva #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) u_sva (.clk,
  .rstn, .regReq, .regWe, .regAddr, .regWdata, .regRvalid, .ramReq, .ramWe, .ramAddr,
  .ramWdata, .ctrlReq, .ctrlWe, .ctrlAddr, .ctrlWdata, .progReq, .progWe, .progAddr,
  .progWdata, .progRdata, .progRvalid, .progRegion, .flashReq, .flashWe, .flashAddr,
  .flashWdata);
